// ### include/fitp_pkg.sv
// constants for the condition pin, interrupt input and timer-expired block
// assumes a 250 MHz pclk and an APB master with 32-bit data
package fitp_pkg;
    localparam int          PIN_COUNT       = 4;
    localparam logic [11:0] COND_DIR_OFS    = 12'h000;
    localparam logic [11:0] COND_OUT_OFS    = 12'h004;
    localparam logic [11:0] COND_IN_OFS     = 12'h008;
    localparam logic [11:0] IRQ_EN_OFS      = 12'h00C;
    localparam logic [11:0] IRQ_EDGE_OFS    = 12'h010;
    localparam logic [11:0] STRAP_OFS       = 12'h014;
    localparam logic [11:0] INT_STAT_OFS    = 12'h018;
    localparam logic [11:0] INT_MASK_OFS    = 12'h01C;
    localparam logic [3:0]  COND_DIR_RST    = 4'h0;
    localparam logic [3:0]  COND_OUT_RST    = 4'h0;
    localparam logic [3:0]  IRQ_EN_RST      = 4'h0;
    localparam logic [3:0]  IRQ_EN_BOOT     = 4'hF;
    localparam logic [3:0]  IRQ_EDGE_RST    = 4'h0;
    localparam logic [5:0]  INT_MASK_RST    = 6'h00;
    localparam int          INT_STRAP_BIT   = 4;
    localparam int          INT_EXPIRE_BIT  = 5;
    localparam int          TMR_PULSE_CYC   = 4;
    localparam logic [2:0]  TMR_PULSE_LAST  = 3'(TMR_PULSE_CYC - 1);
endpackage : fitp_pkg

// ### logic/fitp_top.sv
// condition pins, external interrupt inputs and timer-expired pin with APB registers
// assumes timer0_expire is a one-cycle pulse on pclk; pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module fitp_top (
    // apb
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [11:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // condition pins
    input  wire logic [fitp_pkg::PIN_COUNT-1:0] condition_pins_in,
    output logic      [fitp_pkg::PIN_COUNT-1:0] condition_pins_out,
    output logic      [fitp_pkg::PIN_COUNT-1:0] condition_pins_oe,
    output logic      [fitp_pkg::PIN_COUNT-1:0] condition_test,
    // interrupt inputs, active high after pad inversion
    input  wire logic [fitp_pkg::PIN_COUNT-1:0] ext_interrupt_request_pins,
    output logic      [fitp_pkg::PIN_COUNT-1:0] irq_request,
    // timer expired pin
    input  wire logic                          timer0_expire,
    input  wire logic                          timer0_expired_in,
    output logic                               timer0_expired_out,
    output logic                               timer0_expired_oe,
    output logic                               strap_irq_boot,
    output logic                               irq
);
    import fitp_pkg::*;

    logic [3:0]  cond_dir_reg;
    logic [3:0]  cond_out_reg;
    logic [3:0]  irq_en_reg;
    logic [3:0]  irq_edge_reg;
    logic [5:0]  int_stat_reg;
    logic [5:0]  int_mask_reg;
    logic [3:0]  cond_sync1_reg;
    logic [3:0]  cond_sync2_reg;
    logic [3:0]  irq_sync1_reg;
    logic [3:0]  irq_sync2_reg;
    logic [3:0]  irq_prev_reg;
    logic        strap_sync1_reg;
    logic        strap_sync2_reg;
    logic        rst_done_reg;
    logic        boot_reg;
    logic [2:0]  pulse_cnt_reg;
    logic        pulse_on_reg;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    logic [3:0]  irq_hit;
    logic [5:0]  int_event;
    logic [31:0] rd_next;

    function automatic logic [31:0] zext4(input logic [3:0] v);
        zext4 = {28'h0000000, v};
    endfunction : zext4

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;

    always_comb begin
        addr_ok = 1'b1;
        rd_next = 32'h00000000;
        unique case (paddr)
            COND_DIR_OFS:  rd_next = zext4(cond_dir_reg);
            COND_OUT_OFS:  rd_next = zext4(cond_out_reg);
            COND_IN_OFS:   rd_next = zext4(cond_sync2_reg);
            IRQ_EN_OFS:    rd_next = zext4(irq_en_reg);
            IRQ_EDGE_OFS:  rd_next = zext4(irq_edge_reg);
            STRAP_OFS:     rd_next = {31'h00000000, boot_reg};
            INT_STAT_OFS:  rd_next = {26'h0000000, int_stat_reg};
            INT_MASK_OFS:  rd_next = {26'h0000000, int_mask_reg};
            default:       addr_ok = 1'b0;
        endcase
    end

    // apb: one wait-free access phase, read data latched in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            if (rd_en) begin
                prdata <= rd_next;
            end
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond_dir_reg <= COND_DIR_RST;
            cond_out_reg <= COND_OUT_RST;
            irq_edge_reg <= IRQ_EDGE_RST;
            int_mask_reg <= INT_MASK_RST;
        end else if (wr_en && pready) begin
            unique case (paddr)
                COND_DIR_OFS:  cond_dir_reg <= pwdata[3:0];
                COND_OUT_OFS:  cond_out_reg <= pwdata[3:0];
                IRQ_EDGE_OFS:  irq_edge_reg <= pwdata[3:0];
                INT_MASK_OFS:  int_mask_reg <= pwdata[5:0];
                default:       ;
            endcase
        end
    end

    // strap synchroniser keeps running through reset so the pin level is seen there
    always_ff @(posedge pclk) begin
        strap_sync1_reg <= timer0_expired_in;
        strap_sync2_reg <= strap_sync1_reg;
    end

    // strap capture: synchronised reset-time level taken at the first edge after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_done_reg    <= 1'b0;
            boot_reg        <= 1'b0;
        end else begin
            rst_done_reg    <= 1'b1;
            if (!rst_done_reg) begin
                boot_reg <= strap_sync2_reg;
            end
        end
    end

    // interrupt enables: disabled after reset unless boot strap selects them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_reg <= IRQ_EN_RST;
        end else if (!rst_done_reg) begin
            irq_en_reg <= IRQ_EN_RST;
        end else if (wr_en && pready && paddr == IRQ_EN_OFS) begin
            irq_en_reg <= pwdata[3:0];
        end else if (boot_reg && !strap_irq_boot) begin
            irq_en_reg <= IRQ_EN_BOOT;
        end
    end

    // synchronisers for asynchronous pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond_sync1_reg <= 4'h0;
            cond_sync2_reg <= 4'h0;
            irq_sync1_reg  <= 4'h0;
            irq_sync2_reg  <= 4'h0;
            irq_prev_reg   <= 4'h0;
        end else begin
            cond_sync1_reg <= condition_pins_in;
            cond_sync2_reg <= cond_sync1_reg;
            irq_sync1_reg  <= ext_interrupt_request_pins;
            irq_sync2_reg  <= irq_sync1_reg;
            irq_prev_reg   <= irq_sync2_reg;
        end
    end

    // edge or level detection per input
    assign irq_hit = irq_en_reg & ((~irq_edge_reg & irq_sync2_reg)
                     | (irq_edge_reg & irq_sync2_reg & ~irq_prev_reg));

    // pin outputs and condition tests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            condition_pins_out <= 4'h0;
            condition_pins_oe  <= 4'h0;
            condition_test     <= 4'h0;
            irq_request        <= 4'h0;
            strap_irq_boot     <= 1'b0;
        end else begin
            condition_pins_out <= cond_out_reg;
            condition_pins_oe  <= cond_dir_reg;
            condition_test     <= cond_sync2_reg;
            irq_request        <= irq_hit;
            strap_irq_boot     <= boot_reg;
        end
    end

    // timer expired pulse, four clocks, retriggered by a new expiry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_cnt_reg      <= 3'h0;
            pulse_on_reg       <= 1'b0;
            timer0_expired_out <= 1'b0;
            timer0_expired_oe  <= 1'b0;
        end else begin
            timer0_expired_oe <= rst_done_reg;
            if (timer0_expire && rst_done_reg) begin
                pulse_on_reg  <= 1'b1;
                pulse_cnt_reg <= 3'h0;
            end else if (pulse_on_reg) begin
                if (pulse_cnt_reg == TMR_PULSE_LAST) begin
                    pulse_on_reg <= 1'b0;
                end else begin
                    pulse_cnt_reg <= pulse_cnt_reg + 3'h1;
                end
            end
            timer0_expired_out <= (timer0_expire && rst_done_reg)
                                  | (pulse_on_reg && pulse_cnt_reg != TMR_PULSE_LAST);
        end
    end

    // sticky events: interrupt hits, strap boot seen, timer expiry
    assign int_event = {timer0_expire & rst_done_reg, boot_reg & ~strap_irq_boot, irq_hit};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_reg <= 6'h00;
            irq          <= 1'b0;
        end else begin
            if (wr_en && pready && paddr == INT_STAT_OFS) begin
                int_stat_reg <= (int_stat_reg & ~pwdata[5:0]) | int_event;
            end else begin
                int_stat_reg <= int_stat_reg | int_event;
            end
            irq <= |(int_stat_reg & int_mask_reg);
        end
    end
endmodule : fitp_top
`default_nettype wire

// ### tb/fitp_monitor.sv
// port-level checker for fitp_top, attached by bind
// assumes one pclk domain and presetn async active low
`timescale 1ns/1ps
`default_nettype none
module fitp_monitor (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic [3:0] condition_pins_in,
    input wire logic [3:0] condition_pins_oe,
    input wire logic [3:0] condition_test,
    input wire logic [3:0] irq_request,
    input wire logic       timer0_expire,
    input wire logic       timer0_expired_in,
    input wire logic       timer0_expired_out,
    input wire logic       timer0_expired_oe,
    input wire logic       strap_irq_boot
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_tmr_four_high: assert property (timer0_expire |=> timer0_expired_out [*4])
        else $error("expired pulse shorter than four clocks");
    a_tmr_has_cause: assert property (timer0_expired_out |-> $past(timer0_expire, 1)
        || $past(timer0_expire, 2) || $past(timer0_expire, 3) || $past(timer0_expire, 4))
        else $error("expired pulse longer than four clocks");
    a_reset_outs_off: assert property ($rose(presetn) |-> condition_pins_oe == 4'h0
        && !timer0_expired_oe && irq_request == 4'h0)
        else $error("drivers on after reset");
    a_cond_test_lag: assert property ($past(presetn, 4)
        |-> condition_test == $past(condition_pins_in, 3))
        else $error("condition test not synchronised pin level");
    a_strap_capture: assert property ($rose(presetn)
        |-> ##3 strap_irq_boot == $past(timer0_expired_in, 5))
        else $error("strap not captured from reset level");
    a_strap_holds: assert property ($past(presetn, 3) |-> $stable(strap_irq_boot))
        else $error("strap changed after reset");
    a_tmr_pin_drives: assert property ($past(presetn, 2) |-> timer0_expired_oe)
        else $error("expired pin not output after reset");
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no ready in access phase");
    a_apb_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule : fitp_monitor
bind fitp_top fitp_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr),
    .condition_pins_in(condition_pins_in), .condition_pins_oe(condition_pins_oe),
    .condition_test(condition_test), .irq_request(irq_request),
    .timer0_expire(timer0_expire), .timer0_expired_in(timer0_expired_in),
    .timer0_expired_out(timer0_expired_out), .timer0_expired_oe(timer0_expired_oe),
    .strap_irq_boot(strap_irq_boot));
`default_nettype wire

// ### tb/fitp_board.sv
// board model: condition lines, strap resistor and expired pin resolution
// assumes pins have pull-downs; the bench sets what the board drives
`timescale 1ns/1ps
`default_nettype none
module fitp_board (
    input  wire logic [3:0] cond_out,
    input  wire logic [3:0] cond_oe,
    input  wire logic [3:0] brd_val,
    input  wire logic [3:0] brd_en,
    input  wire logic       tmr_out,
    input  wire logic       tmr_oe,
    input  wire logic       brd_strap,
    output logic      [3:0] cond_in,
    output logic            tmr_in
);
    // undriven lines fall to the pull-down level
    assign cond_in = (cond_oe & cond_out) | (~cond_oe & brd_en & brd_val);
    assign tmr_in  = tmr_oe ? tmr_out : brd_strap;
endmodule : fitp_board
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for fitp_top over APB
// assumes fitp_board on the pins and fitp_monitor bound in
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fitp_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, texp, tin, tout, toe;
    logic strap, irq, b_strap, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic [3:0]  cin, cout, coe, ctest, irqp, ireq, b_val, b_en;
    int bad_count, tests_run, np, n;
    fitp_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .condition_pins_in(cin), .condition_pins_out(cout),
        .condition_pins_oe(coe), .condition_test(ctest), .ext_interrupt_request_pins(irqp),
        .irq_request(ireq), .timer0_expire(texp), .timer0_expired_in(tin),
        .timer0_expired_out(tout), .timer0_expired_oe(toe), .strap_irq_boot(strap), .irq(irq));
    fitp_board u_brd (.cond_out(cout), .cond_oe(coe), .brd_val(b_val), .brd_en(b_en),
        .tmr_out(tout), .tmr_oe(toe), .brd_strap(b_strap), .cond_in(cin), .tmr_in(tin));
    always #2 pclk = ~pclk;
    always @(posedge pclk) if (ireq[0] === 1'b1) np++;
    task automatic results();
        if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
            bad_count++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rq = prdata; err = pslverr;
        psel <= 0; penable <= 0;
        if (k >= 20) begin
            bad_count++;
            results();
        end
        @(posedge pclk);
    endtask : apb
    task automatic rst(input logic s);
        b_strap <= s; presetn <= 0;
        repeat (6) @(posedge pclk);
        chk("oe in reset", 32'h0, {27'h0, toe, coe});
        presetn <= 1;
        repeat (4) @(posedge pclk);
        b_strap <= 0;
        @(posedge pclk);
    endtask : rst
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        texp = 0; irqp = 0; b_val = 0; b_en = 0; b_strap = 0; bad_count = 0; tests_run = 0;
        rst(1);
        apb(0, STRAP_OFS, 0); chk("strap", 32'h1, rq);
        apb(0, IRQ_EN_OFS, 0); chk("boot enable", 32'(IRQ_EN_BOOT), rq);
        rst(0);
        apb(0, IRQ_EN_OFS, 0); chk("enable", 32'h0, rq);
        apb(0, COND_DIR_OFS, 0); chk("dir", 32'h0, rq);
        apb(1, COND_DIR_OFS, 32'h5); apb(1, COND_OUT_OFS, 32'h5);
        b_en <= 4'hA; b_val <= 4'hA;
        repeat (4) @(posedge pclk);
        chk("oe", 32'h5, 32'(coe));
        apb(0, COND_IN_OFS, 0); chk("pin in", 32'hF, rq);
        chk("test", 32'hF, 32'(ctest));
        apb(1, COND_OUT_OFS, 32'h0);
        repeat (4) @(posedge pclk);
        chk("test low", 32'hA, 32'(ctest));
        apb(1, IRQ_EDGE_OFS, 32'h3); apb(1, IRQ_EN_OFS, 32'hF); apb(1, INT_STAT_OFS, 32'h3F);
        np = 0; irqp <= 4'hF;
        repeat (8) @(posedge pclk);
        chk("level req", 32'hC, 32'(ireq));
        chk("edge pulses", 32'h1, 32'(np));
        apb(0, INT_STAT_OFS, 0); chk("status", 32'hF, rq);
        apb(1, INT_MASK_OFS, 0);
        @(posedge pclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1, INT_MASK_OFS, 32'h3F);
        @(posedge pclk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        irqp <= 4'h0;
        repeat (6) @(posedge pclk);
        apb(1, INT_STAT_OFS, 32'hF); apb(0, INT_STAT_OFS, 0); chk("cleared", 32'h0, rq);
        apb(1, IRQ_EN_OFS, 0); irqp <= 4'hF;
        repeat (8) @(posedge pclk);
        chk("disabled req", 32'h0, 32'(ireq));
        irqp <= 4'h0; texp <= 1;
        @(posedge pclk);
        texp <= 0; n = 0;
        repeat (10) begin
            @(posedge pclk);
            if (tout === 1'b1) n++;
        end
        chk("pulse len", 32'(TMR_PULSE_CYC), 32'(n));
        apb(0, INT_STAT_OFS, 0); chk("expiry stat", 32'h1 << INT_EXPIRE_BIT, rq);
        apb(0, 12'hFFC, 0); chk("slverr", 32'h1, {31'h0, err});
        results();
    end
endmodule : tb_top
`default_nettype wire
